// ---- core/memory_timing_control.sv ----
// Contract
// RULE1 - area 1-2 code gives CAS period/latency 1,1,2,3; normal memory waits 0-3.
// RULE2 - area 0 first-cycle waits 0,1,2,3,4,6,8,10; wait pin ignored at zero.
// RULE3 - area 0 burst pitch 2,2,3,4,4,6,8,10 states; wait pin always honoured.
// RULE4 - 16-bit control register times DRAM, synchronous DRAM and pseudo-SRAM.
// RULE5 - power-on reset clears control register; manual reset or standby keep it.
// RULE6 - software programs timing fields once after power-on.
// RULE7 - writing refresh bits, software rewrites other fields unchanged.
// RULE8 - software avoids areas 2 and 3 until register initialised.
// RULE9 - precharge field sets least gap between strobe negation and reassertion.
// RULE10 - synchronous DRAM waits precharge count before next bank-active.
// RULE11 - precharge codes give 1,2,3,4 cycles normally.
// RULE12 - right after self-refresh precharge codes give 2,5,8,11 cycles.
// RULE13 - after SDRAM write, hold bank-active precharge plus 1-3; code 3 unsettable.
// RULE14 - refresh-assert field gives 2,3,4,5 cycles of row strobe.
// RULE15 - pseudo-SRAM refresh strobe asserted for refresh-assert cycles.
// RULE16 - SDRAM: no bank-active for precharge plus refresh-assert after auto-refresh.
// RULE17 - bit 7 always reads 0; software writes 0.
// RULE18 - burst enable: off when clear; page mode or continuous when set.
// RULE19 - synchronous DRAM always bursts.
// RULE20 - size bit: 16-bit bus when 0, 32-bit when 1.
// RULE21 - size bit overrides area bus width register; must be 1 for SDRAM.
// RULE22 - DRAM column width 8,9,10,11 bits per multiplex code.
// RULE23 - refresh enable bit turns refresh on or off.
// RULE24 - mode 0 periodic refresh cuts bus cycle; mode 1 waits then self-refreshes.
// RULE25 - refresh requests ignored while in self-refresh.
// RULE26 - EDO bit picks rising-edge sampling and half-cycle late row negation.
`timescale 1ns/1ns
`default_nettype none
module memory_timing_control #(
  parameter int cnt_w = 5
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // manual reset: low clears sequencing state but keeps the control register
  input wire logic manual_reset_n,
  // memory kind and area bus width
  input wire logic [1:0] mem_kind,
  input wire logic area_bus_wide,
  // external wait pin, asynchronous
  input wire logic wait_pin,
  // timing outputs
  output logic [3:0] area0_first_waits,
  output logic [3:0] area0_burst_states,
  output logic [1:0] area12_cas,
  output logic area0_wait_honoured,
  output logic wait_active,
  output logic bus_wide,
  output logic burst_on,
  output logic [3:0] column_bits,
  output logic sample_rising,
  output logic late_row_negate,
  output logic bank_active_ok,
  output logic refresh_strobe,
  output logic self_refresh,
  output logic cut_bus_cycle
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0] ctrl;
    logic [4:0] waits;
    logic [cnt_w-1:0] hold;
    logic [cnt_w-1:0] strobe;
    logic after_self;
    logic self_ref;
    logic pend_self;
    logic cut;
    logic wsync1;
    logic wsync2;
    logic [31:0] rdata;
    logic ready;
    logic err;
    // decoded levels, registered so every pin leaves a flip-flop
    logic [3:0] first;
    logic [3:0] pitch;
    logic [1:0] cas;
    logic [3:0] col;
    logic honour;
    logic wait_on;
    logic wide;
    logic burst;
    logic rise;
    logic late;
    logic ok;
    logic strobe_on;
  } state_t;

  state_t cur, nxt;
  logic [cnt_w-1:0] pre_cycles;
  logic [cnt_w-1:0] ras_cycles;
  logic [cnt_w-1:0] wr_cycles;
  logic [3:0] w0_first;
  logic [3:0] w0_burst;
  logic [1:0] cas12;
  logic sdram;
  logic apb_wr;
  logic apb_rd;
  logic [15:0] wval;
  logic [5:0] ev;

  // ==========================================================
  // decode of the timing fields
  always_comb begin
    case (cur.ctrl[mem_timing_pkg::precharge_pos +: 2])
      2'h0: pre_cycles = cur.after_self ? cnt_w'(2) : cnt_w'(1); // RULE11 RULE12
      2'h1: pre_cycles = cur.after_self ? cnt_w'(5) : cnt_w'(2);
      2'h2: pre_cycles = cur.after_self ? cnt_w'(8) : cnt_w'(3);
      default: pre_cycles = cur.after_self ? cnt_w'(11) : cnt_w'(4);
    endcase
    ras_cycles = cnt_w'(cur.ctrl[mem_timing_pkg::refresh_assert_pos +: 2]) + cnt_w'(2); // RULE14
    wr_cycles = cnt_w'(cur.ctrl[mem_timing_pkg::write_pre_pos +: 2]) + cnt_w'(1); // RULE13
    case (cur.waits[mem_timing_pkg::area0_wait_pos +: 3])
      3'h0: begin w0_first = 4'h0; w0_burst = 4'h2; end // RULE2 RULE3
      3'h1: begin w0_first = 4'h1; w0_burst = 4'h2; end
      3'h2: begin w0_first = 4'h2; w0_burst = 4'h3; end
      3'h3: begin w0_first = 4'h3; w0_burst = 4'h4; end
      3'h4: begin w0_first = 4'h4; w0_burst = 4'h4; end
      3'h5: begin w0_first = 4'h6; w0_burst = 4'h6; end
      3'h6: begin w0_first = 4'h8; w0_burst = 4'h8; end
      default: begin w0_first = 4'ha; w0_burst = 4'ha; end
    endcase
    // normal memory reads the code as waits, others clamp code 0 to 1
    if (mem_kind == mem_timing_pkg::mem_normal) begin
      cas12 = cur.waits[mem_timing_pkg::area12_wait_pos +: 2]; // RULE1
    end else if (cur.waits[mem_timing_pkg::area12_wait_pos +: 2] == 2'h0) begin
      cas12 = 2'h1;
    end else begin
      cas12 = cur.waits[mem_timing_pkg::area12_wait_pos +: 2];
    end
  end

  assign sdram = (mem_kind == mem_timing_pkg::mem_sdram);
  assign apb_wr = psel & penable & pwrite & ~cur.ready;
  assign apb_rd = psel & penable & ~pwrite & ~cur.ready;
  assign ev = pwdata[5:0];

  // ==========================================================
  // next-state logic
  always_comb begin
    nxt = cur;
    nxt.ready = 1'b0;
    nxt.err = 1'b0;
    nxt.wsync1 = wait_pin;
    nxt.wsync2 = cur.wsync1;
    nxt.cut = 1'b0;
    wval = pwdata[15:0];
    // manual reset keeps the control register; only its sequencing state clears
    // timers count down one per cycle
    if (cur.hold != '0) begin
      nxt.hold = cur.hold - cnt_w'(1); // RULE10
    end
    if (cur.strobe != '0) begin
      nxt.strobe = cur.strobe - cnt_w'(1); // RULE14 RULE15
    end
    if (apb_wr | apb_rd) begin
      nxt.ready = 1'b1;
      nxt.rdata = '0;
      case (paddr)
        mem_timing_pkg::timing_ctrl_addr: begin
          if (apb_wr) begin
            wval[mem_timing_pkg::reserved_pos] = 1'b0; // RULE17
            // a reserved write-precharge code cannot be stored
            if (wval[mem_timing_pkg::write_pre_pos +: 2] == mem_timing_pkg::write_pre_reserved) begin
              wval[mem_timing_pkg::write_pre_pos +: 2] = cur.ctrl[mem_timing_pkg::write_pre_pos +: 2]; // RULE13
            end
            nxt.ctrl = wval; // RULE4
          end
          nxt.rdata = {16'h0000, cur.ctrl};
        end
        mem_timing_pkg::wait_ctrl_addr: begin
          if (apb_wr) begin
            nxt.waits = pwdata[4:0];
          end
          nxt.rdata = {27'h0, cur.waits};
        end
        mem_timing_pkg::status_addr: begin
          nxt.rdata = {12'h000, cur.after_self, cur.pend_self, cur.self_ref,
            (cur.hold == '0), w0_first, w0_burst, 2'h0, cas12, 4'h0};
        end
        mem_timing_pkg::event_addr: begin
          if (apb_wr) begin
            // precharge done: row or chip strobe may not reassert before the gap
            if (ev[mem_timing_pkg::ev_precharge_pos]) begin
              nxt.hold = pre_cycles; // RULE9 RULE10
              nxt.after_self = 1'b0;
            end
            if (ev[mem_timing_pkg::ev_write_pos] & sdram) begin
              nxt.hold = pre_cycles + wr_cycles; // RULE13
              nxt.after_self = 1'b0;
            end
            if (ev[mem_timing_pkg::ev_autoref_pos] & ~cur.self_ref) begin
              nxt.strobe = ras_cycles; // RULE15
              if (sdram) begin
                nxt.hold = pre_cycles + ras_cycles; // RULE16
              end
            end
            // refresh request: ignored in self-refresh
            if (ev[mem_timing_pkg::ev_refresh_req_pos] & ~cur.self_ref &
                cur.ctrl[mem_timing_pkg::refresh_en_pos]) begin // RULE25 RULE23
              if (cur.ctrl[mem_timing_pkg::refresh_mode_pos]) begin
                nxt.pend_self = 1'b1; // RULE24
              end else begin
                nxt.cut = 1'b1; // RULE24
                nxt.strobe = ras_cycles;
              end
            end
            if (ev[mem_timing_pkg::ev_bus_idle_pos] & cur.pend_self) begin
              nxt.pend_self = 1'b0;
              nxt.self_ref = 1'b1; // RULE24
            end
            if (ev[mem_timing_pkg::ev_selfexit_pos] & cur.self_ref) begin
              nxt.self_ref = 1'b0;
              nxt.after_self = 1'b1; // RULE12
            end
          end
        end
        default: begin
          nxt.err = 1'b1;
        end
      endcase
    end
    // refresh turned off drops self-refresh and pending entry
    if (~nxt.ctrl[mem_timing_pkg::refresh_en_pos]) begin
      nxt.pend_self = 1'b0; // RULE23
      if (cur.self_ref) begin
        nxt.after_self = 1'b1;
      end
      nxt.self_ref = 1'b0;
    end
    // decoded outputs, one cycle behind the registers they come from, except ok and strobe_on, which track hold and strobe
    // a manual reset clears them for one cycle; they settle again on the next edge, except wait_on, which takes three as the pin synchroniser refills
    nxt.first = w0_first;
    nxt.pitch = w0_burst;
    nxt.cas = cas12; // RULE1
    nxt.honour = (w0_first != 4'h0); // RULE2
    // with burst enabled the pin is always honoured; otherwise only with first-cycle waits
    nxt.wait_on = cur.wsync2 & ((w0_first != 4'h0) | cur.burst); // RULE3
    nxt.wide = (mem_kind == mem_timing_pkg::mem_normal) ? area_bus_wide
      : cur.ctrl[mem_timing_pkg::size_pos]; // RULE20 RULE21
    nxt.burst = sdram | cur.ctrl[mem_timing_pkg::burst_pos]; // RULE18 RULE19
    nxt.col = 4'h8 + {2'h0, cur.ctrl[mem_timing_pkg::addr_mux_pos +: 2]}; // RULE22
    nxt.rise = (mem_kind == mem_timing_pkg::mem_dram) & cur.ctrl[mem_timing_pkg::edo_pos]; // RULE26
    nxt.late = (mem_kind == mem_timing_pkg::mem_dram) & cur.ctrl[mem_timing_pkg::edo_pos];
    nxt.ok = (nxt.hold == '0); // RULE10
    nxt.strobe_on = (nxt.strobe != '0); // RULE14 RULE15
  end

  // ==========================================================
  // registers; control register cleared only on power-on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
      cur.ctrl <= mem_timing_pkg::timing_ctrl_reset; // RULE5
      cur.waits <= mem_timing_pkg::wait_ctrl_reset;
    end else if (!manual_reset_n) begin
      cur <= '0;
      cur.ctrl <= cur.ctrl; // RULE5
      cur.waits <= cur.waits;
    end else begin
      cur <= nxt;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign area0_first_waits = cur.first;
  assign area0_burst_states = cur.pitch;
  assign area12_cas = cur.cas;
  assign area0_wait_honoured = cur.honour;
  assign wait_active = cur.wait_on;
  assign bus_wide = cur.wide;
  assign burst_on = cur.burst;
  assign column_bits = cur.col;
  assign sample_rising = cur.rise;
  assign late_row_negate = cur.late;
  assign bank_active_ok = cur.ok;
  assign refresh_strobe = cur.strobe_on;
  assign self_refresh = cur.self_ref;
  assign cut_bus_cycle = cur.cut;
  assign prdata = cur.rdata;
  assign pready = cur.ready;
  assign pslverr = cur.err;

  // ==========================================================
  // checks
  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn) cur.ctrl[mem_timing_pkg::reserved_pos] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // RULE17

  property p_no_reserved_wr;
    @(posedge pclk) disable iff (!presetn)
      cur.ctrl[mem_timing_pkg::write_pre_pos +: 2] != mem_timing_pkg::write_pre_reserved;
  endproperty
  a_no_reserved_wr: assert property (p_no_reserved_wr) else $error("reserved write delay stored"); // RULE13

  property p_sdram_burst;
    @(posedge pclk) disable iff (!presetn) sdram && manual_reset_n |=> burst_on || !$past(sdram);
  endproperty
  a_sdram_burst: assert property (p_sdram_burst) else $error("sdram without burst"); // RULE19

  property p_self_ignore;
    @(posedge pclk) disable iff (!presetn) self_refresh |=> !cut_bus_cycle && !$rose(refresh_strobe);
  endproperty
  a_self_ignore: assert property (p_self_ignore) else $error("refresh during self-refresh"); // RULE25

  property p_refresh_off;
    @(posedge pclk) disable iff (!presetn) !cur.ctrl[mem_timing_pkg::refresh_en_pos] |-> !cur.self_ref;
  endproperty
  a_refresh_off: assert property (p_refresh_off) else $error("self-refresh with refresh off"); // RULE23

  property p_hold_blocks;
    @(posedge pclk) disable iff (!presetn) (cur.hold > cnt_w'(1)) |=> !bank_active_ok;
  endproperty
  a_hold_blocks: assert property (p_hold_blocks) else $error("bank active too early"); // RULE10

  property p_first_zero;
    @(posedge pclk) disable iff (!presetn)
      (cur.waits[2:0] == 3'h0) |=> (area0_first_waits == 4'h0) || $changed(cur.waits);
  endproperty
  a_first_zero: assert property (p_first_zero) else $error("area0 zero wait decode"); // RULE2

  property p_cas_clamp;
    @(posedge pclk) disable iff (!presetn)
      (manual_reset_n && mem_kind == mem_timing_pkg::mem_dram && cur.waits[4:3] == 2'h0 && $stable(cur.waits))
      |=> area12_cas == 2'h1;
  endproperty
  a_cas_clamp: assert property (p_cas_clamp) else $error("cas period clamp"); // RULE1

  // checks on what the pins show, and on the control register across a manual reset
  property p_manual_keep;
    @(posedge pclk) disable iff (!presetn)
      !manual_reset_n |=> cur.ctrl == $past(cur.ctrl);
  endproperty
  a_manual_keep: assert property (p_manual_keep) else $error("manual reset changed control"); // RULE5

  property p_wide_override;
    @(posedge pclk) disable iff (!presetn)
      manual_reset_n && mem_kind != mem_timing_pkg::mem_normal |=> bus_wide == $past(cur.ctrl[5]);
  endproperty
  a_wide_override: assert property (p_wide_override) else $error("size bit not in force"); // RULE21

  property p_cut_pulse;
    @(posedge pclk) disable iff (!presetn)
      cut_bus_cycle |=> !cut_bus_cycle;
  endproperty
  a_cut_pulse: assert property (p_cut_pulse) else $error("cut pulse too long"); // RULE24

  property p_strobe_min;
    @(posedge pclk) disable iff (!presetn)
      $rose(refresh_strobe) && manual_reset_n |=> refresh_strobe;
  endproperty
  a_strobe_min: assert property (p_strobe_min) else $error("refresh strobe too short"); // RULE14

  // scenarios worth seeing
  c_self: cover property (@(posedge pclk) disable iff (!presetn) $rose(cur.self_ref));
  c_cut: cover property (@(posedge pclk) disable iff (!presetn) cur.cut);
  c_after: cover property (@(posedge pclk) disable iff (!presetn) $rose(cur.after_self));
  c_hold: cover property (@(posedge pclk) disable iff (!presetn) $fell(bank_active_ok));
  c_edo: cover property (@(posedge pclk) disable iff (!presetn) sample_rising);
endmodule
`default_nettype wire

// ---- core/mem_timing_pkg.sv ----
package mem_timing_pkg;
  // ==========================================================
  // register map
  localparam logic [11:0] timing_ctrl_addr = 12'h000;  // memory_timing_control
  localparam logic [11:0] wait_ctrl_addr = 12'h004;    // area 0 and 1-2 wait fields
  localparam logic [11:0] status_addr = 12'h008;       // decoded timing and state
  localparam logic [11:0] event_addr = 12'h00c;        // event strobes
  localparam logic [15:0] timing_ctrl_reset = 16'h0000;
  localparam logic [4:0] wait_ctrl_reset = 5'h1f;
  // ==========================================================
  // field positions in memory_timing_control
  localparam int precharge_pos = 14;
  localparam int row_col_pos = 12;
  localparam int write_pre_pos = 10;
  localparam int refresh_assert_pos = 8;
  localparam int reserved_pos = 7;
  localparam int burst_pos = 6;
  localparam int size_pos = 5;
  localparam int addr_mux_pos = 3;
  localparam int refresh_en_pos = 2;
  localparam int refresh_mode_pos = 1;
  localparam int edo_pos = 0;
  // field positions in the wait register
  localparam int area0_wait_pos = 0;
  localparam int area12_wait_pos = 3;
  // event register bits
  localparam int ev_precharge_pos = 0;
  localparam int ev_write_pos = 1;
  localparam int ev_autoref_pos = 2;
  localparam int ev_selfexit_pos = 3;
  localparam int ev_refresh_req_pos = 4;
  localparam int ev_bus_idle_pos = 5;
  // memory kinds
  localparam logic [1:0] mem_normal = 2'h0;
  localparam logic [1:0] mem_dram = 2'h1;
  localparam logic [1:0] mem_sdram = 2'h2;
  localparam logic [1:0] mem_psram = 2'h3;
  localparam logic [1:0] write_pre_reserved = 2'h3;
endpackage

// ---- tb/mem_partner.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// far-side memory: wait line and strobe timing
module mem_partner (
  // clock
  input wire logic pclk,
  // from the controller
  input wire logic refresh_strobe,
  input wire logic cut_bus_cycle,
  // bench asks the memory to stretch its cycle
  input wire logic hold_bus,
  // to the controller and the bench
  output logic wait_pin,
  output int strobe_len,
  output int cut_seen
);
  int run = 0;
  // wait line is a plain level, the controller synchronises it
  assign wait_pin = hold_bus;
  // length of the last strobe, cut pulses counted, not judged here
  always @(posedge pclk) begin
    if (refresh_strobe === 1'b1) begin
      run <= run + 1;
    end else begin
      if (run != 0) strobe_len <= run;
      run <= 0;
    end
    if (cut_bus_cycle === 1'b1) cut_seen <= cut_seen + 1;
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ==========================================
  // clock, reset, stimulus
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, e, manual_reset_n = 1, area_bus_wide = 0, hold_bus = 0, wait_pin;
  logic [1:0] mem_kind = 2'h0, area12_cas;
  logic [3:0] first_w, burst_s, column_bits;
  logic honoured, wait_active, bus_wide, burst_on, sample_rising, late_row_negate;
  logic bank_active_ok, refresh_strobe, self_refresh, cut_bus_cycle;
  int err_count = 0, n_tests = 0, strobe_len, cut_seen, low_run = 0, last_low = 0;
  logic [31:0] ctrl;
  always #25 pclk = ~pclk;
  memory_timing_control u_memory_timing_control (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .manual_reset_n(manual_reset_n), .mem_kind(mem_kind),
    .area_bus_wide(area_bus_wide), .wait_pin(wait_pin), .area0_first_waits(first_w),
    .area0_burst_states(burst_s), .area12_cas(area12_cas), .area0_wait_honoured(honoured),
    .wait_active(wait_active), .bus_wide(bus_wide), .burst_on(burst_on), .column_bits(column_bits),
    .sample_rising(sample_rising), .late_row_negate(late_row_negate), .bank_active_ok(bank_active_ok),
    .refresh_strobe(refresh_strobe), .self_refresh(self_refresh), .cut_bus_cycle(cut_bus_cycle));
  mem_partner u_mem_partner (.pclk(pclk), .refresh_strobe(refresh_strobe), .cut_bus_cycle(cut_bus_cycle),
    .hold_bus(hold_bus), .wait_pin(wait_pin), .strobe_len(strobe_len), .cut_seen(cut_seen));
  // length of the last stretch with bank-active held off
  always @(posedge pclk) begin
    if (bank_active_ok === 1'b1) begin
      if (low_run != 0) last_low <= low_run;
      low_run <= 0;
    end else low_run <= low_run + 1;
  end
  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // apb cycle: setup, access held until pready seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no limit here: a slave that never answers is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic event_hit(input int b);
    apb(1, mem_timing_pkg::event_addr, 32'h1 << b);
    repeat (14) @(posedge pclk);
  endtask
  task automatic complete_run;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    apb(0, mem_timing_pkg::timing_ctrl_addr, 0); chk(q, 32'h0);
    apb(0, mem_timing_pkg::wait_ctrl_addr, 0); chk(q, 32'h1f);
    chk(first_w, 32'ha); chk(burst_s, 32'ha); chk(area12_cas, 32'h3);
    apb(0, 12'h7f0, 0); chk(e, 32'h1); // unmapped address refused
    $display("reset values done");
  endtask
  // every area 0 and area 1-2 code, wait line held by the memory
  task automatic t_waits;
    int fw[8] = '{0, 1, 2, 3, 4, 6, 8, 10};
    int bs[8] = '{2, 2, 3, 4, 4, 6, 8, 10};
    int cs[4] = '{1, 1, 2, 3};
    hold_bus <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      // first half as normal memory, second half as DRAM with its clamped code
      mem_kind <= (i < 4) ? mem_timing_pkg::mem_normal : mem_timing_pkg::mem_dram;
      apb(1, mem_timing_pkg::wait_ctrl_addr, i | ((i & 3) << 3));
      chk(first_w, fw[i]);
      chk(burst_s, bs[i]);
      chk(area12_cas, (i < 4) ? (i & 3) : cs[i & 3]);
      chk(honoured, i != 0);
      chk(wait_active, i != 0);
    end
    hold_bus <= 1'b0;
    $display("wait codes done");
  endtask
  // reserved bit, unsettable write delay, column widths, size and burst
  task automatic t_ctrl;
    apb(1, 0, 32'hffff_ffff);
    apb(0, 0, 0); chk(q, 32'h0000_f37f);
    for (int i = 0; i < 4; i++) begin
      // pass 1 is synchronous memory with burst bit clear; fast sampling only with DRAM
      ctrl = (i << 3) | ((i & 1) << 5) | ((i >> 1) << 6) | (i == 3);
      mem_kind <= (i == 1) ? mem_timing_pkg::mem_sdram : mem_timing_pkg::mem_dram;
      area_bus_wide <= ~ctrl[5];
      apb(1, 0, ctrl);
      chk(column_bits, 8 + i);
      chk(bus_wide, ctrl[5]);
      chk(burst_on, ctrl[6] | (i == 1));
      chk(sample_rising, ctrl[0]);
      chk(late_row_negate, ctrl[0]);
    end
    @(posedge pclk) manual_reset_n <= 1'b0;
    @(posedge pclk) manual_reset_n <= 1'b1;
    apb(0, 0, 0); chk(q, ctrl);
    $display("control fields done");
  endtask
  // bank-active hold-offs for synchronous memory
  task automatic t_hold;
    mem_kind <= mem_timing_pkg::mem_sdram;
    ctrl = 32'h4b20;
    apb(1, 0, ctrl);
    event_hit(0); chk(last_low, 2);
    event_hit(1); chk(last_low, 5);
    event_hit(2); chk(last_low, 7);
    $display("hold-off done");
  endtask
  // refresh, self-refresh entry, ignored requests, exit
  task automatic t_refresh;
    mem_kind <= mem_timing_pkg::mem_dram;
    apb(1, 0, ctrl | 32'h4);
    event_hit(4);
    chk(cut_seen, 1); chk(strobe_len, 5);
    apb(1, 0, ctrl | 32'h6);
    event_hit(4); chk(self_refresh, 0);
    event_hit(5); chk(self_refresh, 1);
    event_hit(4); chk(cut_seen, 1);
    event_hit(3); chk(self_refresh, 0);
    mem_kind <= mem_timing_pkg::mem_sdram;
    event_hit(0); chk(last_low, 5);
    $display("refresh done");
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_waits();
    t_ctrl();
    t_hold();
    t_refresh();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
